// ---- logic/srw_pkg.sv ----
// constants, types and helpers shared by the supervisory reset watchdog
package srw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timebase
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_TIME_NS    = 1_000_000;
  // one millisecond of clock cycles, least time so rounded up
  localparam int CYCLES_PER_MS = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIV_W         = 14;

  ////////////////////////////////////////////////////////////////////////////
  // millisecond intervals
  localparam int                MS_W         = 11;
  localparam int                HOLD_W       = 9;
  localparam int                PBD_W        = 4;
  localparam logic [HOLD_W-1:0] HOLD_MS      = 9'h0FA;
  // one extra tick so a partial first millisecond never shortens the hold
  localparam logic [HOLD_W-1:0] HOLD_LOAD    = HOLD_MS + 9'h001;
  localparam logic [HOLD_W-1:0] HOLD_LAST    = 9'h001;
  localparam logic [HOLD_W-1:0] HOLD_ZERO    = 9'h000;
  localparam logic [PBD_W-1:0]  PBD_MS       = 4'h4;
  localparam logic [PBD_W-1:0]  PBD_ZERO     = 4'h0;
  localparam logic [PBD_W-1:0]  PBD_STEP     = 4'h1;
  localparam logic [MS_W-1:0]   PER_GND_MS   = 11'h096;
  localparam logic [MS_W-1:0]   PER_OPEN_MS  = 11'h258;
  localparam logic [MS_W-1:0]   PER_VCC_MS   = 11'h4B0;
  localparam logic [MS_W-1:0]   MS_ZERO      = 11'h000;
  localparam logic [MS_W-1:0]   MS_STEP      = 11'h001;

  ////////////////////////////////////////////////////////////////////////////
  // input synchroniser lanes and strap capture
  localparam int       SYNC_W      = 6;
  localparam int       SYN_SUPPLY  = 0;
  localparam int       SYN_MANUAL  = 1;
  localparam int       SYN_STROBE  = 2;
  localparam int       SYN_PER_LO  = 3;
  localparam int       SYN_PER_HI  = 4;
  localparam int       SYN_TOL     = 5;
  // idle levels: strobe and pushbutton high, all else low
  localparam logic [SYNC_W-1:0] SYNC_RST = 6'h06;
  localparam logic [1:0] START_WAIT  = 2'h3;
  localparam logic [1:0] START_STEP  = 2'h1;
  localparam logic [1:0] STRAP_PIN_GND  = 2'h0;
  localparam logic [1:0] STRAP_PIN_OPEN = 2'h1;

  typedef enum logic [1:0] {STRAP_GND, STRAP_OPEN, STRAP_VCC} srw_strap_t;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic srw_strap_t strap_decode(input logic [1:0] pins);
    srw_strap_t s;
    s = STRAP_VCC;
    if (pins == STRAP_PIN_GND)
    begin
      s = STRAP_GND;
    end
    else if (pins == STRAP_PIN_OPEN)
    begin
      s = STRAP_OPEN;
    end
    return s;
  endfunction

  function automatic logic [MS_W-1:0] period_ms(input srw_strap_t s);
    logic [MS_W-1:0] p;
    p = PER_VCC_MS;
    case (s)
      STRAP_GND:  p = PER_GND_MS;
      STRAP_OPEN: p = PER_OPEN_MS;
      default:    p = PER_VCC_MS;
    endcase
    return p;
  endfunction

endpackage

// ---- logic/srw_debounce.sv ----
// pushbutton debouncer sampled on the millisecond tick
`timescale 1ns/1ps
module srw_debounce
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  // sampled input
  input  wire logic i_tick,
  input  wire logic i_level_n,
  // debounced press
  output logic      o_pressed
);

  logic [srw_pkg::PBD_W-1:0] low_ms_q;
  logic                      pressed_q;

  ////////////////////////////////////////////////////////////////////////////
  // count consecutive low samples, short glitches never reach the delay
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      low_ms_q <= srw_pkg::PBD_ZERO;
    end
    else if (i_tick)
    begin
      if (i_level_n)
      begin
        low_ms_q <= srw_pkg::PBD_ZERO;
      end
      else if (low_ms_q != srw_pkg::PBD_MS)
      begin
        low_ms_q <= low_ms_q + srw_pkg::PBD_STEP;
      end
    end
  end

  // press recognised only after the pushbutton delay of held low
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pressed_q <= 1'b0;
    end
    else if (i_tick)
    begin
      if (i_level_n)
      begin
        pressed_q <= 1'b0;
      end
      else if (low_ms_q == srw_pkg::PBD_MS - srw_pkg::PBD_STEP)
      begin
        pressed_q <= 1'b1;
      end
    end
  end

  assign o_pressed = pressed_q;

  ////////////////////////////////////////////////////////////////////////////
  chk_press_delay: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    $rose(pressed_q) |-> $past(i_tick) && !$past(i_level_n)
      && $past(low_ms_q) == srw_pkg::PBD_MS - srw_pkg::PBD_STEP)
    else $error("press recognised before the pushbutton delay");

  chk_glitch_ignored: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    (i_tick && i_level_n) |=> !pressed_q && low_ms_q == srw_pkg::PBD_ZERO)
    else $error("high sample did not clear the debouncer");

endmodule

// ---- logic/srw_top.sv ----
// supervisory reset generator with supply monitor, pushbutton and watchdog
`timescale 1ns/1ps
module srw_top
#(
  parameter int P_CYCLES_PER_MS = srw_pkg::CYCLES_PER_MS
)
(
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_arst_n,
  // supervised inputs
  input  wire logic       i_supply_low,
  input  wire logic       i_manual_reset_n,
  input  wire logic       i_strobe_n,
  // straps
  input  wire logic [1:0] i_period_select,
  input  wire logic       i_tolerance_select,
  // threshold choice to the comparator
  output logic            o_threshold_10pct,
  // reset outputs
  output logic            o_reset,
  input  wire logic       i_reset_n_i,
  output logic            o_reset_n_o,
  output logic            o_reset_n_oe
);

  localparam logic [srw_pkg::DIV_W-1:0] DIV_LAST = srw_pkg::DIV_W'(P_CYCLES_PER_MS - 1);
  localparam logic [srw_pkg::DIV_W-1:0] DIV_ZERO = '0;
  localparam logic [srw_pkg::DIV_W-1:0] DIV_STEP = srw_pkg::DIV_W'(1);

  logic [srw_pkg::SYNC_W-1:0] meta_q;
  logic [srw_pkg::SYNC_W-1:0] sync_q;
  logic                       supply_low_s;
  logic                       manual_n_s;
  logic                       strobe_n_s;
  logic                       strobe_prev_q;
  logic                       strobe_fall;
  logic [1:0]                 start_q;
  logic                       straps_ok_q;
  srw_pkg::srw_strap_t        per_q;
  logic                       tol_q;
  logic [srw_pkg::DIV_W-1:0]  div_q;
  logic                       ms_tick;
  logic                       mr_pressed;
  logic [srw_pkg::MS_W-1:0]   wd_ms_q;
  logic [srw_pkg::MS_W-1:0]   wd_limit;
  logic                       wd_expire;
  logic [srw_pkg::HOLD_W-1:0] hold_q;
  logic                       any_src;
  logic                       reset_d;
  logic                       reset_q;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for every supervised input and strap pin
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      meta_q <= srw_pkg::SYNC_RST;
      sync_q <= srw_pkg::SYNC_RST;
    end
    else
    begin
      meta_q <= {i_tolerance_select, i_period_select, i_strobe_n,
                 i_manual_reset_n, i_supply_low};
      sync_q <= meta_q;
    end
  end

  assign supply_low_s = sync_q[srw_pkg::SYN_SUPPLY];
  assign manual_n_s   = sync_q[srw_pkg::SYN_MANUAL];
  assign strobe_n_s   = sync_q[srw_pkg::SYN_STROBE];

  ////////////////////////////////////////////////////////////////////////////
  // straps caught once the synchronisers have filled after release
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      start_q     <= 2'h0;
      straps_ok_q <= 1'b0;
    end
    else if (!straps_ok_q)
    begin
      start_q     <= start_q + srw_pkg::START_STEP;
      straps_ok_q <= (start_q == srw_pkg::START_WAIT);
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      per_q <= srw_pkg::STRAP_GND;
      tol_q <= 1'b0;
    end
    else if (!straps_ok_q && start_q == srw_pkg::START_WAIT)
    begin
      per_q <= srw_pkg::strap_decode(sync_q[srw_pkg::SYN_PER_HI:srw_pkg::SYN_PER_LO]);
      tol_q <= sync_q[srw_pkg::SYN_TOL];
    end
  end

  assign o_threshold_10pct = tol_q;

  ////////////////////////////////////////////////////////////////////////////
  // millisecond timebase
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      div_q <= DIV_ZERO;
    end
    else if (div_q == DIV_LAST)
    begin
      div_q <= DIV_ZERO;
    end
    else
    begin
      div_q <= div_q + DIV_STEP;
    end
  end

  assign ms_tick = (div_q == DIV_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // pushbutton
  srw_debounce u_debounce
  (
    .i_clock   (i_clock),
    .i_arst_n  (i_arst_n),
    .i_tick    (ms_tick),
    .i_level_n (manual_n_s),
    .o_pressed (mr_pressed)
  );

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, held at zero while reset is active so pulses repeat each period
  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      strobe_prev_q <= 1'b1;
    end
    else
    begin
      strobe_prev_q <= strobe_n_s;
    end
  end

  assign strobe_fall = strobe_prev_q & ~strobe_n_s;
  assign wd_limit    = srw_pkg::period_ms(per_q) - srw_pkg::MS_STEP;
  assign wd_expire   = ms_tick && !reset_q && !strobe_fall && (wd_ms_q == wd_limit);

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      wd_ms_q <= srw_pkg::MS_ZERO;
    end
    else if (strobe_fall || reset_q || wd_expire)
    begin
      wd_ms_q <= srw_pkg::MS_ZERO;
    end
    else if (ms_tick)
    begin
      wd_ms_q <= wd_ms_q + srw_pkg::MS_STEP;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset hold: any source reloads, good time counts down per millisecond
  assign any_src = supply_low_s | mr_pressed | wd_expire;

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      hold_q <= srw_pkg::HOLD_LOAD;
    end
    else if (any_src)
    begin
      hold_q <= srw_pkg::HOLD_LOAD;
    end
    else if (ms_tick && hold_q != srw_pkg::HOLD_ZERO)
    begin
      hold_q <= hold_q - srw_pkg::HOLD_LAST;
    end
  end

  assign reset_d = any_src | (hold_q != srw_pkg::HOLD_ZERO);

  always_ff @(posedge i_clock or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      reset_q <= 1'b1;
    end
    else
    begin
      reset_q <= reset_d;
    end
  end

  // open-drain: pull low exactly while the high output is active
  assign o_reset      = reset_q;
  assign o_reset_n_o  = 1'b0;
  assign o_reset_n_oe = reset_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_pulse_start;
    reset_q && hold_q == srw_pkg::HOLD_LOAD;
  endsequence

  sequence s_pulse_holds;
    reset_q [*8];
  endsequence

  chk_outputs_complementary: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    o_reset_n_oe == o_reset && !o_reset_n_o)
    else $error("reset outputs not complementary");

  chk_supply_forces_reset: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    supply_low_s |=> s_pulse_start)
    else $error("supply low did not force reset");

  chk_supply_good_time: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    $fell(reset_q) |-> $past(hold_q) == srw_pkg::HOLD_ZERO
      && $past(hold_q, 2) == srw_pkg::HOLD_LAST && $past(ms_tick, 2))
    else $error("reset released before hold ran out");

  chk_release_hold: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    $fell(mr_pressed) |-> s_pulse_start ##1 s_pulse_holds)
    else $error("pushbutton release did not hold reset");

  chk_strobe_restart: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    strobe_fall |=> wd_ms_q == srw_pkg::MS_ZERO)
    else $error("strobe falling edge did not restart watchdog");

  chk_rising_ignored: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    ($rose(strobe_n_s) && ms_tick && !reset_q && !wd_expire)
      |=> wd_ms_q == $past(wd_ms_q) + srw_pkg::MS_STEP)
    else $error("strobe rising edge disturbed watchdog");

  chk_timeout_pulse: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    wd_expire |=> s_pulse_start ##1 s_pulse_holds)
    else $error("watchdog timeout gave no reset pulse");

  // strap to period mapping spelled out apart from the period helper
  chk_period_select: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    wd_expire |-> wd_ms_q + srw_pkg::MS_STEP
      == ((per_q == srw_pkg::STRAP_GND) ? srw_pkg::PER_GND_MS
        : (per_q == srw_pkg::STRAP_OPEN) ? srw_pkg::PER_OPEN_MS : srw_pkg::PER_VCC_MS))
    else $error("watchdog expired at the wrong period");

  chk_repeat_timeout: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    (reset_q && !reset_d) |=> wd_ms_q == srw_pkg::MS_ZERO && !reset_q)
    else $error("watchdog did not restart after a reset pulse");

  chk_tolerance_out: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    (straps_ok_q && $past(straps_ok_q)) |-> o_threshold_10pct == tol_q && $stable(tol_q))
    else $error("tolerance choice changed after capture");

  chk_manual_reset: assert property (
    @(posedge i_clock) disable iff (!i_arst_n)
    $rose(mr_pressed) |=> reset_q)
    else $error("pushbutton press did not reset");

endmodule

// ---- tb/srw_proc_model.sv ----
// processor model that toggles the watchdog strobe
`timescale 1ns/1ps
module srw_proc_model
#(
  parameter int P_HALF = 20
)
(
  // clock
  input  wire logic i_clock,
  // control from the bench
  input  wire logic i_run,
  // strobe to the supervisor
  output logic      o_strobe_n
);
  int cnt = 0;
  initial o_strobe_n = 1'b1;
  // high phase from foreground, low phase from interrupt code
  // low phase one cycle longer so edges meet every timebase phase
  always @(posedge i_clock)
  begin
    if (i_run)
    begin
      if (cnt >= P_HALF - 1 + int'(!o_strobe_n))
      begin
        cnt <= 0;
        o_strobe_n <= ~o_strobe_n;
      end
      else
      begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the supervisory reset watchdog
`timescale 1ns/1ps
module tb_top;
  localparam int MS   = 10;
  localparam int HOLD = 250 * MS;
  int         per_ms [3] = '{150, 600, 1200};
  int         n_errors = 0;
  int         samples_checked = 0;
  int         n;
  int         p;
  logic       i_clock = 1'b0;
  logic       i_arst_n = 1'b0;
  logic       i_supply_low = 1'b0;
  logic       i_manual_reset_n = 1'b1;
  logic [1:0] i_period_select = 2'h0;
  logic       i_tolerance_select = 1'b0;
  logic       tol_v = 1'b0;
  logic       run = 1'b0;
  logic       strobe_n;
  logic       o_threshold_10pct;
  logic       o_reset;
  logic       o_reset_n_o;
  logic       o_reset_n_oe;
  wire        reset_n_wire = o_reset_n_oe ? o_reset_n_o : 1'b1;

  always #50 i_clock = ~i_clock;

  srw_top #(.P_CYCLES_PER_MS(MS)) DUT
  (
    .i_clock            (i_clock),
    .i_arst_n           (i_arst_n),
    .i_supply_low       (i_supply_low),
    .i_manual_reset_n   (i_manual_reset_n),
    .i_strobe_n         (strobe_n),
    .i_period_select    (i_period_select),
    .i_tolerance_select (i_tolerance_select),
    .o_threshold_10pct  (o_threshold_10pct),
    .o_reset            (o_reset),
    .i_reset_n_i        (reset_n_wire),
    .o_reset_n_o        (o_reset_n_o),
    .o_reset_n_oe       (o_reset_n_oe)
  );

  srw_proc_model #(.P_HALF(20)) proc
  (
    .i_clock    (i_clock),
    .i_run      (run),
    .o_strobe_n (strobe_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (n_errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input int seen, input int lo, input int hi);
    samples_checked++;
    if (seen < lo || seen > hi)
    begin
      $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, seen);
      n_errors++;
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clock);
  endtask

  // cycles until reset output reaches lvl, lim if never
  task automatic measure(input logic lvl, input int lim, output int k);
    k = 0;
    #1;
    while (k < lim && o_reset !== lvl)
    begin
      @(posedge i_clock);
      #1;
      k++;
    end
  endtask

  task automatic do_reset(input logic [1:0] sel, input logic tolerance_select);
    @(posedge i_clock);
    i_arst_n <= 1'b0;
    i_period_select <= sel;
    i_tolerance_select <= tolerance_select;
    cyc(4);
    i_arst_n <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // both reset outputs checked every cycle while i_arst_n is high
  always @(negedge i_clock)
  begin
    if (i_arst_n === 1'b1)
    begin
      samples_checked++;
      if (reset_n_wire !== ~o_reset || o_reset_n_oe !== o_reset || $isunknown(o_reset))
      begin
        $display("Error reset_n expected %b seen %b", ~o_reset, reset_n_wire);
        n_errors++;
      end
    end
  end

  initial
  begin
    repeat (100000) @(posedge i_clock);
    n_errors++;
    give_verdict();
  end

  initial
  begin
    n = $urandom(32'h4D52);
    for (int s = 0; s < 3; s++)
    begin
      p = per_ms[s] * MS;
      tol_v = 1'($urandom % 2);
      do_reset((s == 2) ? 2'(2 + $urandom % 2) : 2'(s), tol_v);
      measure(1'b0, 3000, n);
      chk("powerup", n, HOLD, HOLD + 40);
      chk("threshold", int'(o_threshold_10pct === tol_v), 1, 1);
      if (s == 0)
      begin
        cyc(1);
        i_supply_low <= 1'b1;
        measure(1'b1, 10, n);
        chk("supply_rise", n, 2, 5);
        cyc(30);
        i_supply_low <= 1'b0;
        cyc(1000);
        i_supply_low <= 1'b1;
        cyc(20);
        i_supply_low <= 1'b0;
        measure(1'b0, 3000, n);
        chk("supply_hold", n, HOLD, HOLD + 40);
        cyc(1);
        i_manual_reset_n <= 1'b0;
        cyc(1 + $urandom % 8);
        i_manual_reset_n <= 1'b1;
        measure(1'b1, 200, n);
        chk("pb_short", n, 200, 200);
        cyc(1);
        i_manual_reset_n <= 1'b0;
        measure(1'b1, 200, n);
        chk("pb_delay", n, 25, 50);
        cyc(200);
        i_manual_reset_n <= 1'b1;
        measure(1'b0, 3000, n);
        chk("pb_hold", n, HOLD, HOLD + 40);
      end
      cyc(1);
      run <= 1'b1;
      @(negedge strobe_n);
      run <= 1'b0;
      measure(1'b1, p + 30, n);
      chk("timeout", n, p - 15, p + 15);
      measure(1'b0, 3000, n);
      chk("wd_pulse", n, HOLD, HOLD + 40);
      measure(1'b1, p + 30, n);
      chk("repeat", n, p - 15, p + 15);
      cyc(1);
      run <= 1'b1;
      measure(1'b0, 3000, n);
      chk("wd_pulse2", n, HOLD - 20, HOLD + 40);
      measure(1'b1, p + 200, n);
      chk("strobed", n, p + 200, p + 200);
      cyc(1);
      run <= 1'b0;
    end
    give_verdict();
  end
endmodule
